// ---- ccsc_pkg.sv ----
// What this block does
// - entry point register sets core start address
// - value 0x02 selects internal frame pulse
// - halt register set blocks any core start
// - core starts on run bit rising edge
// - prescaler divides master clock by 1,2,4,8
// - synthesizer makes 294.912 MHz from 3.072 MHz
// - reduced-speed variant halves synthesizer output
// - enable bit restarts synthesizer lock attempt
// - lock flag set once output is stable
// - lock typically within 3.5 ms
// - clock output register controls buffered clock pin
// - master clock accepted from 2.375 to 36 MHz
// - crystal runs at core clock over 24
`default_nettype none
package ccsc_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_FB_DIV    = 16'hF000;
    localparam logic [15:0] IDX_PRESCALE  = 16'hF001;
    localparam logic [15:0] IDX_CLK_SRC   = 16'hF002;
    localparam logic [15:0] IDX_SYN_EN    = 16'hF003;
    localparam logic [15:0] IDX_LOCK      = 16'hF004;
    localparam logic [15:0] IDX_CLK_OUT   = 16'hF005;
    localparam logic [15:0] IDX_HIBERNATE = 16'hF400;
    localparam logic [15:0] IDX_FRAME_SRC = 16'hF401;
    localparam logic [15:0] IDX_RUN       = 16'hF402;
    localparam logic [15:0] IDX_HALT      = 16'hF403;
    localparam logic [15:0] IDX_ENTRY     = 16'hF404;
    // memory window below the control registers
    localparam logic [15:0] IDX_PROG_MEM  = 16'hC000;
    localparam logic [15:0] IDX_DM0       = 16'h0000;
    localparam logic [15:0] IDX_DM1       = 16'h6000;
    localparam logic [15:0] IDX_MEM_END   = 16'hF000;
    localparam int          ADDR_W        = 18;

    localparam logic [15:0] RST_FB_DIV    = 16'h0060;
    localparam logic [15:0] RST_ZERO      = 16'h0000;
    localparam logic [15:0] FRAME_SRC_INT = 16'h0002;
    localparam int          BIT_CTL       = 0;
    localparam int          PRE_LSB       = 0;
    localparam int          PRE_MSB       = 1;

    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    localparam real CLK_PERIOD_NS = 8.0;
    localparam real LOCK_TYP_MS   = 3.5;
    localparam real MCLK_MIN_MHZ  = 2.375;
    localparam real MCLK_MAX_MHZ  = 36.0;
    localparam real NOM_CORE_MHZ  = 294.912;
    localparam real NOM_SYN_IN_MHZ = 3.072;
    localparam int  XTAL_RATIO    = 24;
    localparam int  LOCK_CYCLES   = $rtoi(LOCK_TYP_MS * 1.0e6 / CLK_PERIOD_NS);
    // shortest and longest accepted edge spacing, both rounded down
    localparam int  MCLK_MIN_PER  = $rtoi(1.0e3 / MCLK_MAX_MHZ / CLK_PERIOD_NS);
    localparam int  MCLK_MAX_PER  = $rtoi(1.0e3 / MCLK_MIN_MHZ / CLK_PERIOD_NS);
    localparam int  NOM_FB_RATIO  = $rtoi(NOM_CORE_MHZ / NOM_SYN_IN_MHZ + 0.5);
    localparam int  FRAME_CYCLES  = 2604;
endpackage : ccsc_pkg
`default_nettype wire

// ---- ccsc_top.sv ----
// Design decision made here: register access over AXI4-Lite.
`default_nettype none
module ccsc_top #(
    parameter int LOCK_CYC      = ccsc_pkg::LOCK_CYCLES,
    parameter int FRAME_CYC     = ccsc_pkg::FRAME_CYCLES,
    parameter bit REDUCED_SPEED = 1'b0
) (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    // axi4-lite write address, data and response
    input  wire logic [ccsc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                  s_axi_awprot,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    // axi4-lite read
    input  wire logic [ccsc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                  s_axi_arprot,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // clock and frame pulse pins
    input  wire logic                        master_clock_input_pin,
    output logic                             buffered_clock_output_pin,
    input  wire logic                        ext_frame_pulse,
    // towards the core and clock tree
    output logic                             prescaled_tick,
    output logic [15:0]                      core_clk_mult,
    output logic [4:0]                       core_clk_div,
    output logic                             core_clk_sel_synth,
    output logic                             synth_locked,
    output logic                             core_start_pulse,
    output logic                             core_active,
    output logic [15:0]                      core_entry_addr,
    output logic                             core_frame_start,
    output logic                             core_hibernating
);
    import ccsc_pkg::*;

    logic [15:0] fb_div_r, prescale_r, clk_src_r, syn_en_r, clk_out_r;
    logic [15:0] hib_r, frame_src_r, run_r, halt_r, entry_r;

    // write channel: address and data are held until both are present
    logic                 aw_held_r, w_held_r;
    logic [ADDR_W-1:0]    aw_addr_r;
    logic [31:0]          w_data_r;
    logic [3:0]           w_strb_r;
    logic                 wr_go;
    logic [15:0]          wr_idx;
    logic                 wr_hit, wr_mem;

    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
    assign wr_go         = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_idx        = aw_addr_r[ADDR_W-1:2];
    assign wr_mem        = wr_idx < IDX_MEM_END;

    always_comb begin
        case (wr_idx)
            IDX_FB_DIV, IDX_PRESCALE, IDX_CLK_SRC, IDX_SYN_EN, IDX_LOCK, IDX_CLK_OUT,
            IDX_HIBERNATE, IDX_FRAME_SRC, IDX_RUN, IDX_HALT, IDX_ENTRY: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            w_held_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end
    end

    // memory image writes are taken and acknowledged; storage lives in the core
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_hit || wr_mem) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [15:0] v;
        v       = old;
        v[7:0]  = s[0] ? d[7:0] : old[7:0];
        v[15:8] = s[1] ? d[15:8] : old[15:8];
        return v;
    endfunction

    logic [15:0] wr_val;
    assign wr_val = merge(16'h0000, w_data_r, w_strb_r);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fb_div_r    <= RST_FB_DIV;
            prescale_r  <= RST_ZERO;
            clk_src_r   <= RST_ZERO;
            syn_en_r    <= RST_ZERO;
            clk_out_r   <= RST_ZERO;
            hib_r       <= RST_ZERO;
            frame_src_r <= RST_ZERO;
            run_r       <= RST_ZERO;
            halt_r      <= RST_ZERO;
            entry_r     <= RST_ZERO;
        end else if (wr_go) begin
            case (wr_idx)
                IDX_FB_DIV:    fb_div_r    <= merge(fb_div_r, w_data_r, w_strb_r);
                IDX_PRESCALE:  prescale_r  <= merge(prescale_r, w_data_r, w_strb_r);
                IDX_CLK_SRC:   clk_src_r   <= merge(clk_src_r, w_data_r, w_strb_r);
                IDX_SYN_EN:    syn_en_r    <= merge(syn_en_r, w_data_r, w_strb_r);
                IDX_CLK_OUT:   clk_out_r   <= merge(clk_out_r, w_data_r, w_strb_r);
                IDX_HIBERNATE: hib_r       <= merge(hib_r, w_data_r, w_strb_r);
                IDX_FRAME_SRC: frame_src_r <= merge(frame_src_r, w_data_r, w_strb_r);
                IDX_RUN:       run_r       <= merge(run_r, w_data_r, w_strb_r);
                IDX_HALT:      halt_r      <= merge(halt_r, w_data_r, w_strb_r);
                IDX_ENTRY:     entry_r     <= merge(entry_r, w_data_r, w_strb_r);
                default: ;
            endcase
        end
    end

    // read channel: one outstanding read, answer one cycle after the address
    logic [15:0] rd_idx;
    assign rd_idx        = s_axi_araddr[ADDR_W-1:2];
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (rd_idx)
                IDX_FB_DIV:    s_axi_rdata <= {16'h0000, fb_div_r};
                IDX_PRESCALE:  s_axi_rdata <= {16'h0000, prescale_r};
                IDX_CLK_SRC:   s_axi_rdata <= {16'h0000, clk_src_r};
                IDX_SYN_EN:    s_axi_rdata <= {16'h0000, syn_en_r};
                IDX_LOCK:      s_axi_rdata <= {31'h00000000, synth_locked};
                IDX_CLK_OUT:   s_axi_rdata <= {16'h0000, clk_out_r};
                IDX_HIBERNATE: s_axi_rdata <= {16'h0000, hib_r};
                IDX_FRAME_SRC: s_axi_rdata <= {16'h0000, frame_src_r};
                IDX_RUN:       s_axi_rdata <= {16'h0000, run_r};
                IDX_HALT:      s_axi_rdata <= {16'h0000, halt_r};
                IDX_ENTRY:     s_axi_rdata <= {16'h0000, entry_r};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= (rd_idx < IDX_MEM_END) ? RESP_OKAY : RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // pin synchronisers
    logic [1:0] mclk_sync_r, frm_sync_r;
    logic       mclk_prev_r, frm_prev_r, mclk_rise;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mclk_sync_r <= 2'b00;
            frm_sync_r  <= 2'b00;
            mclk_prev_r <= 1'b0;
            frm_prev_r  <= 1'b0;
        end else begin
            mclk_sync_r <= {mclk_sync_r[0], master_clock_input_pin};
            frm_sync_r  <= {frm_sync_r[0], ext_frame_pulse};
            mclk_prev_r <= mclk_sync_r[1];
            frm_prev_r  <= frm_sync_r[1];
        end
    end
    assign mclk_rise = mclk_sync_r[1] && !mclk_prev_r;

    // edge spacing of the master clock decides whether it is in range
    logic [5:0] per_cnt_r;
    logic       mclk_ok_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            per_cnt_r <= '0;
            mclk_ok_r <= 1'b0;
        end else if (mclk_rise) begin
            per_cnt_r <= 6'h01;
            mclk_ok_r <= (per_cnt_r >= 6'(MCLK_MIN_PER)) && (per_cnt_r <= 6'(MCLK_MAX_PER));
        end else if (per_cnt_r > 6'(MCLK_MAX_PER)) begin
            mclk_ok_r <= 1'b0;
        end else begin
            per_cnt_r <= per_cnt_r + 6'h01;
        end
    end

    // prescaler: one tick per 1, 2, 4 or 8 master clock edges
    logic [2:0] pre_cnt_r;
    logic [2:0] pre_max;
    assign pre_max = 3'((4'h1 << prescale_r[PRE_MSB:PRE_LSB]) - 4'h1);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pre_cnt_r      <= '0;
            prescaled_tick <= 1'b0;
        end else begin
            prescaled_tick <= mclk_rise && (pre_cnt_r >= pre_max);
            if (mclk_rise) begin
                pre_cnt_r <= (pre_cnt_r >= pre_max) ? 3'h0 : pre_cnt_r + 3'h1;
            end
        end
    end

    // ratio presented to the clock tree: mclk * fb / (prescale * post)
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            core_clk_mult      <= RST_FB_DIV;
            core_clk_div       <= 5'h01;
            core_clk_sel_synth <= 1'b0;
        end else begin
            core_clk_mult      <= fb_div_r;
            // shift amount kept 3 bits wide so divide-by-8 plus halving cannot wrap
            core_clk_div       <= 5'h01 << ({1'b0, prescale_r[PRE_MSB:PRE_LSB]}
                                  + (REDUCED_SPEED ? 3'd1 : 3'd0));
            core_clk_sel_synth <= clk_src_r[BIT_CTL] && synth_locked;
        end
    end

    // lock model: restart on every enable write with byte 0 strobed, count while input is good
    logic        en_wr;
    logic [31:0] lock_cnt_r;
    logic        locking_r;
    assign en_wr = wr_go && (wr_idx == IDX_SYN_EN) && w_strb_r[0];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            locking_r    <= 1'b0;
            lock_cnt_r   <= '0;
            synth_locked <= 1'b0;
        end else if (en_wr) begin
            locking_r    <= wr_val[BIT_CTL];
            lock_cnt_r   <= '0;
            synth_locked <= 1'b0;
        end else if (!mclk_ok_r) begin
            // a lost input drops the flag and starts the wait over
            lock_cnt_r   <= '0;
            synth_locked <= 1'b0;
        end else if (locking_r && !synth_locked) begin
            if (lock_cnt_r >= 32'(LOCK_CYC - 1)) begin
                synth_locked <= 1'b1;
            end else begin
                lock_cnt_r <= lock_cnt_r + 32'h1;
            end
        end
    end

    // buffered clock out follows the synced master clock, crystal pin plays no part
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            buffered_clock_output_pin <= 1'b0;
        end else begin
            // the synced master clock is passed on here while the clock output bit is set
            buffered_clock_output_pin <= clk_out_r[BIT_CTL] && mclk_sync_r[1];
        end
    end

    // core start: rising edge of the run bit while not halted
    logic run_prev_r, run_rise;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            run_prev_r <= 1'b0;
        end else begin
            run_prev_r <= run_r[BIT_CTL];
        end
    end
    assign run_rise = run_r[BIT_CTL] && !run_prev_r;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            core_start_pulse <= 1'b0;
            core_active      <= 1'b0;
            core_entry_addr  <= RST_ZERO;
        end else begin
            core_start_pulse <= run_rise && !halt_r[BIT_CTL];
            if (halt_r[BIT_CTL]) begin
                core_active <= 1'b0;
            end else if (run_rise) begin
                core_active     <= 1'b1;
                core_entry_addr <= entry_r;
            end
        end
    end

    // frame pulse: internal divider or the synced external pulse
    logic [15:0] frm_cnt_r;
    logic        int_tick, frm_int;
    assign frm_int  = frame_src_r == FRAME_SRC_INT;
    assign int_tick = frm_cnt_r == 16'(FRAME_CYC - 1);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frm_cnt_r        <= '0;
            core_frame_start <= 1'b0;
        end else begin
            frm_cnt_r        <= int_tick ? 16'h0000 : frm_cnt_r + 16'h0001;
            core_frame_start <= core_active && (frm_int ? int_tick
                                : (frm_sync_r[1] && !frm_prev_r));
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            core_hibernating <= 1'b0;
        end else begin
            core_hibernating <= hib_r[BIT_CTL];
        end
    end

    // ---- assertions ----
    a_halt_blocks_start: assert property (@(posedge sys_clk) disable iff (rst)
        halt_r[BIT_CTL] |=> !core_start_pulse)
        else $error("core started while halted");

    a_start_on_edge: assert property (@(posedge sys_clk) disable iff (rst)
        core_start_pulse |-> $past(run_r[BIT_CTL]) && !$past(run_prev_r))
        else $error("core start without run bit rising edge");

    a_entry_on_start: assert property (@(posedge sys_clk) disable iff (rst)
        core_start_pulse |-> core_entry_addr == $past(entry_r) && core_active)
        else $error("entry address not taken at start");

    a_frame_internal: assert property (@(posedge sys_clk) disable iff (rst)
        (core_active && frm_int && int_tick) |=> core_frame_start)
        else $error("internal frame pulse missing");

    a_enable_clears_lock: assert property (@(posedge sys_clk) disable iff (rst)
        en_wr |=> !synth_locked ##1 !synth_locked)
        else $error("lock flag survived enable write");

    a_lock_not_early: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(synth_locked) |-> $past(lock_cnt_r) == 32'(LOCK_CYC - 1))
        else $error("lock flag set before lock time");

    a_lock_needs_input: assert property (@(posedge sys_clk) disable iff (rst)
        synth_locked |-> $past(mclk_ok_r) && locking_r)
        else $error("lock flag without good input");

    a_prescale_ratio: assert property (@(posedge sys_clk) disable iff (rst)
        (prescale_r[PRE_MSB:PRE_LSB] == 2'd0 && $stable(prescale_r) && mclk_rise)
        |=> prescaled_tick)
        else $error("divide-by-one prescaler dropped an edge");

    a_buffered_clock_output_pin_gated: assert property (@(posedge sys_clk) disable iff (rst)
        !clk_out_r[BIT_CTL] |=> !buffered_clock_output_pin)
        else $error("clock output driven while disabled");

    a_unmapped_slverr: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_go && !wr_hit && !wr_mem) |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");

    a_rvalid_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped before taken");

    c_core_start: cover property (@(posedge sys_clk) disable iff (rst)
        core_start_pulse ##[1:20] core_frame_start);
    c_lock_reached: cover property (@(posedge sys_clk) disable iff (rst)
        $rose(synth_locked));
    c_start_refused: cover property (@(posedge sys_clk) disable iff (rst)
        run_rise && halt_r[BIT_CTL]);

endmodule : ccsc_top // ccsc_top
`default_nettype wire

// ---- ccsc_mclk_model.sv ----
`default_nettype none
module ccsc_mclk_model (
    // control from the bench
    input  wire logic run,
    input  wire logic slow,
    // master clock pin
    output var logic  mclk
);
    timeunit 1ns;
    timeprecision 1ps;
    // free-running source unrelated in phase to sys_clk; slow drops it below range
    initial begin
        mclk = 1'b0;
        forever begin
            if (run) begin
                #(slow ? 250.0 : 37.0);
                mclk = ~mclk;
            end else begin
                mclk = 1'b0;
                #10;
            end
        end
    end
endmodule // ccsc_mclk_model
`default_nettype wire

// ---- ccsc_top_bench.sv ----
`default_nettype none
module ccsc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ccsc_pkg::*;
    logic        sys_clk, rst, awv, wv, bre, arv, rre, run, slow, ext, pm, pb;
    logic        awr, wrdy, bv, arr, rv, mclk, bco, tick, csel, lck, stp, act, frm, hib;
    logic [17:0] awa, ara;
    logic [31:0] wd, rdat;
    logic [3:0]  ws;
    logic [2:0]  ap;
    logic [1:0]  br, rr;
    logic [15:0] mult, entry;
    logic [4:0]  cdiv;
    int          err_count, checks_done, starts, frames, tog, me, tk, n, dv;

    ccsc_top #(.LOCK_CYC(50), .FRAME_CYC(20)) uut (
        .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awprot(ap),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arprot(ap), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .master_clock_input_pin(mclk), .buffered_clock_output_pin(bco),
        .ext_frame_pulse(ext), .prescaled_tick(tick), .core_clk_mult(mult),
        .core_clk_div(cdiv), .core_clk_sel_synth(csel), .synth_locked(lck),
        .core_start_pulse(stp), .core_active(act), .core_entry_addr(entry),
        .core_frame_start(frm), .core_hibernating(hib));
    ccsc_mclk_model mdl (.run(run), .slow(slow), .mclk(mclk));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // event counters sampled mid-cycle, away from the launching edge
    always @(negedge sys_clk) begin
        if (stp === 1'b1) starts++;
        if (frm === 1'b1) frames++;
        if (tick === 1'b1) tk++;
        if (bco !== pb) tog++;
        if (mclk === 1'b1 && pm === 1'b0) me++;
        pb = bco;
        pm = mclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic [1:0] er);
        logic a, w, b;
        logic [1:0] r;
        int i;
        @(posedge sys_clk);
        awa <= {idx, 2'b00};
        wd <= {16'h0000, d};
        ws <= 4'h3;
        ap <= 3'h0;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        i = 0;
        do begin
            @(negedge sys_clk);
            a = awv & awr;
            w = wv & wrdy;
            b = bv;
            r = br;
            @(posedge sys_clk);
            if (a) awv <= 1'b0;
            if (w) wv <= 1'b0;
            i++;
        end while (!b && i < 50);
        bre <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
    endtask

    task automatic rd(input logic [15:0] idx, input logic [15:0] ed, input logic [1:0] er);
        logic a, v;
        logic [31:0] d;
        logic [1:0] r;
        int i;
        @(posedge sys_clk);
        ara <= {idx, 2'b00};
        arv <= 1'b1;
        rre <= 1'b1;
        i = 0;
        do begin
            @(negedge sys_clk);
            a = arv & arr;
            v = rv;
            d = rdat;
            r = rr;
            @(posedge sys_clk);
            if (a) arv <= 1'b0;
            i++;
        end while (!v && i < 50);
        rre <= 1'b0;
        chk(d, {16'h0000, ed});
        chk({30'h0, r}, {30'h0, er});
    endtask

    task automatic lock_up;
        wr(IDX_SYN_EN, 16'h0001, RESP_OKAY);
        n = 0;
        while (lck !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
        chk(n >= 40 && n <= 70, 1);
    endtask

    initial begin
        #200_000;
        err_count++;
        print_verdict;
    end

    initial begin
        rst = 1'b1;
        {awv, wv, bre, arv, rre, slow, ext, awa, ara, wd, ws, ap} = '0;
        run = 1'b1;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rd(IDX_FB_DIV, RST_FB_DIV, RESP_OKAY);
        chk(cdiv, 5'h01);
        wr(IDX_PROG_MEM, 16'hA5A5, RESP_OKAY);
        wr(IDX_DM0, 16'hA5A5, RESP_OKAY);
        wr(IDX_DM1, 16'hA5A5, RESP_OKAY);
        wr(16'hF010, 16'h0001, RESP_SLVERR);
        rd(16'hF010, 16'h0000, RESP_SLVERR);
        wr(IDX_HALT, 16'h0001, RESP_OKAY);
        wr(IDX_HIBERNATE, 16'h0001, RESP_OKAY);
        wr(IDX_FB_DIV, 16'h0060, RESP_OKAY);
        wr(IDX_CLK_SRC, 16'h0001, RESP_OKAY);
        for (int p = 0; p < 4; p++) begin
            wr(IDX_PRESCALE, 16'(p), RESP_OKAY);
            cyc(2);
            chk(cdiv, 5'(1 << p));
            tk = 0;
            me = 0;
            cyc(400);
            dv = (tk << p) - me;
            chk(dv <= (2 << p) && dv >= -(2 << p), 1);
        end
        wr(IDX_PRESCALE, 16'h0002, RESP_OKAY);
        cyc(2);
        chk(mult, 16'(NOM_FB_RATIO));
        wr(IDX_CLK_OUT, 16'h0000, RESP_OKAY);
        tog = 0;
        cyc(100);
        chk(tog, 0);
        wr(IDX_CLK_OUT, 16'h0005, RESP_OKAY);
        tog = 0;
        cyc(100);
        chk(tog >= 16, 1);
        lock_up;
        rd(IDX_LOCK, 16'h0001, RESP_OKAY);
        wr(IDX_LOCK, 16'h0000, RESP_OKAY);
        rd(IDX_LOCK, 16'h0001, RESP_OKAY);
        chk(csel, 1'b1);
        // an out-of-range master clock must cost the lock
        @(posedge sys_clk) slow <= 1'b1;
        cyc(150);
        chk(lck, 1'b0);
        @(posedge sys_clk) slow <= 1'b0;
        // let the range check see two good edges before the lock time is measured
        cyc(60);
        lock_up;
        wr(IDX_ENTRY, 16'h1234, RESP_OKAY);
        wr(IDX_FRAME_SRC, FRAME_SRC_INT, RESP_OKAY);
        wr(IDX_RUN, 16'h0000, RESP_OKAY);
        wr(IDX_RUN, 16'h0001, RESP_OKAY);
        cyc(5);
        chk(starts, 0);
        chk(act, 1'b0);
        wr(IDX_HALT, 16'h0000, RESP_OKAY);
        wr(IDX_RUN, 16'h0000, RESP_OKAY);
        wr(IDX_RUN, 16'h0001, RESP_OKAY);
        cyc(5);
        chk(starts, 1);
        chk(act, 1'b1);
        chk(entry, 16'h1234);
        frames = 0;
        cyc(200);
        chk(frames >= 9 && frames <= 11, 1);
        wr(IDX_FRAME_SRC, 16'h0000, RESP_OKAY);
        frames = 0;
        cyc(100);
        chk(frames, 0);
        repeat (2) begin
            @(posedge sys_clk) ext <= 1'b1;
            cyc(4);
            @(posedge sys_clk) ext <= 1'b0;
            cyc(4);
        end
        cyc(5);
        chk(frames, 2);
        chk(hib, 1'b1);
        cyc(6250);
        wr(IDX_HIBERNATE, 16'h0000, RESP_OKAY);
        cyc(2);
        chk(hib, 1'b0);
        print_verdict;
    end
endmodule // ccsc_top_bench
`default_nettype wire
